//--- common/qmwb_defines.svh
// opcodes, field positions, reset values and timing counts of the flash command link
`ifndef QMWB_DEFINES_SVH
`define QMWB_DEFINES_SVH
// ==========================================
// opcodes
`define QMWB_OP_ENTER_4W   8'h38
`define QMWB_OP_EXIT_4W    8'hFF
`define QMWB_OP_SET_PARAM  8'hC0
`define QMWB_OP_SET_WRAP   8'h77
`define QMWB_OP_FAST_READ  8'h0B
`define QMWB_OP_QIO_READ   8'hEB
`define QMWB_OP_WRAP_READ  8'h0C
`define QMWB_OP_LOCK       8'h36
`define QMWB_OP_UNLOCK     8'h39
// ==========================================
// fields and reset values
`define QMWB_DUMMY_FLD_LSB 4
`define QMWB_WRAP_FLD_LSB  0
`define QMWB_SWRAP_FLD_LSB 4
`define QMWB_RST_DUMMY_FLD 2'h0
`define QMWB_RST_WRAP_FLD  2'h0
`define QMWB_SERIAL_DUMMY  4'h8
`define QMWB_LOCK_BLOCKS   16
`define QMWB_LOCK_IDX_LSB  20
// ==========================================
// link timing
`define QMWB_CLK_PERIOD_NS  10
`define QMWB_SCLK_PERIOD_NS 160
`define QMWB_SCLK_HALF_CYC  ((`QMWB_SCLK_PERIOD_NS / 2) / `QMWB_CLK_PERIOD_NS)
// ==========================================
// host register offsets
`define QMWB_REG_CMD    8'h00
`define QMWB_REG_ADDR   8'h04
`define QMWB_REG_PARAM  8'h08
`define QMWB_REG_CFG    8'h0C
`define QMWB_REG_STATUS 8'h10
`define QMWB_REG_RDATA  8'h14
`endif

//--- common/qmwb_pkg.sv
// types of the flash command link
`include "qmwb_defines.svh"
package qmwb_pkg;
  typedef enum logic [2:0] {
    DS_OPC, DS_ADDR, DS_PARAM, DS_DUMMY, DS_DATA, DS_HOLD, DS_SKIP
  } qmwb_dev_state_type;

  typedef enum logic [1:0] {HS_IDLE, HS_CS, HS_RUN, HS_END} qmwb_host_state_type;

  typedef enum logic [2:0] {
    HP_OPC, HP_ADDR, HP_PARAM, HP_DUMMY, HP_DATA
  } qmwb_phase_type;

  typedef struct packed {
    qmwb_dev_state_type             st;
    logic                           four_wire;
    logic [1:0]                     dummy_fld;
    logic [1:0]                     wrap_fld;
    logic [`QMWB_LOCK_BLOCKS-1:0]   locks;
    logic [7:0]                     opc;
    logic [31:0]                    sh;
    logic [5:0]                     cnt;
    logic [31:0]                    addr;
    logic [7:0]                     rbyte;
    logic                           nib;
    logic                           req;
    logic [3:0]                     io_o;
    logic                           io_oe_n;
  } qmwb_dev_regs_type;

  typedef struct packed {
    logic [2:0] cs_n;
    logic [2:0] sclk;
    logic [3:0] io1;
    logic [3:0] io2;
  } qmwb_sync_regs_type;
endpackage : qmwb_pkg

//--- common/qmwb_link_if.sv
// four-line flash command link between host controller and flash device
`timescale 1ns/1ps
`default_nettype none
interface qmwb_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe_n;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe_n;
  logic [3:0] io;

  // resolved wire level, lines float high when nobody drives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = !h_io_oe_n[i] ? h_io_o[i] : (!d_io_oe_n[i] ? d_io_o[i] : 1'b1);
    end
  end

  modport device (input cs_n, input sclk, input io, output d_io_o, output d_io_oe_n);
  modport host (output cs_n, output sclk, output h_io_o, output h_io_oe_n, input io);
endinterface : qmwb_link_if
`default_nettype wire

//--- hdl/qmwb_link_sync.sv
// two-flop synchroniser of the link pins with clock edge detection
`timescale 1ns/1ps
`default_nettype none
module qmwb_link_sync
  import qmwb_pkg::*;
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // raw pins
  input  wire logic       i_cs_n,
  input  wire logic       i_sclk,
  input  wire logic [3:0] i_io,
  // synchronised view
  output logic            o_cs_n,
  output logic            o_cs_rise,
  output logic            o_sclk_rise,
  output logic            o_sclk_fall,
  output logic [3:0]      o_io
);
  qmwb_sync_regs_type q, d;

  always_comb begin
    d      = q;
    d.cs_n = {q.cs_n[1:0], i_cs_n};
    d.sclk = {q.sclk[1:0], i_sclk};
    d.io1  = i_io;
    d.io2  = q.io1;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      q <= '{cs_n: 3'h7, sclk: 3'h0, io1: 4'hF, io2: 4'hF};
    end else begin
      q <= d;
    end
  end

  // stage 0 is read only by stage 1
  assign o_cs_n      = q.cs_n[1];
  assign o_cs_rise   = q.cs_n[1] & ~q.cs_n[2];
  assign o_sclk_rise = q.sclk[1] & ~q.sclk[2];
  assign o_sclk_fall = ~q.sclk[1] & q.sclk[2];
  assign o_io        = q.io2;
endmodule : qmwb_link_sync
`default_nettype wire

//--- hdl/qmwb_device.sv
// flash device end: four-wire mode, read parameters, wrap read, block locks
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "qmwb_defines.svh"
module qmwb_device
  import qmwb_pkg::*;
(
  // clock and reset
  input  wire logic                         i_clock,
  input  wire logic                         i_rst,
  // link
  qmwb_link_if.device                       link,
  // status and configuration inputs
  input  wire logic                         i_soft_reset,
  input  wire logic                         i_quad_enable_bit,
  input  wire logic                         i_four_byte_addr,
  input  wire logic                         i_protect_scheme_select,
  input  wire logic                         i_legacy_protected,
  // protection query
  input  wire logic [31:0]                  i_query_addr,
  output logic                              o_query_protected,
  // array read port
  output logic                              o_read_req,
  output logic [31:0]                       o_read_addr,
  input  wire logic [7:0]                   i_read_data,
  // state
  output logic                              o_four_wire_mode,
  output logic [3:0]                        o_dummy_clocks,
  output logic [6:0]                        o_wrap_bytes,
  output logic [`QMWB_LOCK_BLOCKS-1:0]      o_lock_bits
);
  localparam int LIDX = $clog2(`QMWB_LOCK_BLOCKS);

  qmwb_dev_regs_type q, d;
  logic       cs_n_s;
  logic       cs_rise;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [3:0] io_s;

  // ==========================================
  // helpers
  // dummy field decode
  function automatic logic [3:0] dummy_of(input logic [1:0] fld);
    dummy_of = {1'b0, fld, 1'b0} + 4'h2;
  endfunction : dummy_of

  function automatic logic [6:0] wrap_of(input logic [1:0] fld);
    wrap_of = 7'h08 << fld;
  endfunction : wrap_of

  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic wrap,
                                            input logic [1:0] fld);
    logic [31:0] m;
    m = wrap ? {25'h0, wrap_of(fld) - 7'h01} : 32'hFFFF_FFFF;
    next_addr = (a & ~m) | ((a + 32'h1) & m);
  endfunction : next_addr

  function automatic logic [LIDX-1:0] lock_idx(input logic [31:0] a);
    lock_idx = a[`QMWB_LOCK_IDX_LSB +: LIDX];
  endfunction : lock_idx

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == `QMWB_OP_FAST_READ) || (op == `QMWB_OP_QIO_READ) ||
              (op == `QMWB_OP_WRAP_READ);
  endfunction : is_read

  // ==========================================
  // pin synchroniser
  qmwb_link_sync u_sync (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_cs_n      (link.cs_n),
    .i_sclk      (link.sclk),
    .i_io        (link.io),
    .o_cs_n      (cs_n_s),
    .o_cs_rise   (cs_rise),
    .o_sclk_rise (sclk_rise),
    .o_sclk_fall (sclk_fall),
    .o_io        (io_s)
  );

  // ==========================================
  // command interpreter
  always_comb begin
    logic [31:0] sh_n;
    logic [5:0]  cnt_n;
    logic [5:0]  step;
    logic [5:0]  abits;
    logic [5:0]  pbits;
    d     = q;
    d.req = 1'b0;
    step  = q.four_wire ? 6'd4 : 6'd1;
    sh_n  = q.four_wire ? {q.sh[27:0], io_s} : {q.sh[30:0], io_s[0]};
    cnt_n = q.cnt + step;
    abits = i_four_byte_addr ? 6'd32 : 6'd24;
    // one parameter byte; the serial wrap command carries three pad bytes first
    pbits = (q.opc == `QMWB_OP_SET_PARAM) ? 6'd8 : 6'd32;
    if (q.req) begin
      d.rbyte = i_read_data;
    end
    if (cs_n_s) begin
      d.st      = DS_OPC;
      d.cnt     = 6'd0;
      d.nib     = 1'b0;
      d.io_oe_n = 1'b1;
      // act only on a complete frame
      if (cs_rise && q.st == DS_HOLD) begin
        case (q.opc)
          // parameters and wrap left untouched
          `QMWB_OP_ENTER_4W: d.four_wire = i_quad_enable_bit;
          `QMWB_OP_EXIT_4W: d.four_wire = 1'b0;
          `QMWB_OP_LOCK: d.locks[lock_idx(q.addr)] = 1'b1;
          `QMWB_OP_UNLOCK: d.locks[lock_idx(q.addr)] = 1'b0;
          default: d.st = DS_OPC;
        endcase
      end
    end else if (sclk_rise) begin
      case (q.st)
        DS_OPC: begin
          d.sh  = sh_n;
          d.cnt = cnt_n;
          if (cnt_n == 6'd8) begin
            d.opc = sh_n[7:0];
            d.cnt = 6'd0;
            case (sh_n[7:0])
              // enter only from serial, exit only from four-wire
              `QMWB_OP_ENTER_4W: d.st = q.four_wire ? DS_SKIP : DS_HOLD;
              `QMWB_OP_EXIT_4W: d.st = q.four_wire ? DS_HOLD : DS_SKIP;
              // parameters refused in serial mode, wrap refused in four-wire mode, settings kept
              `QMWB_OP_SET_PARAM: d.st = q.four_wire ? DS_PARAM : DS_SKIP;
              `QMWB_OP_SET_WRAP: d.st = q.four_wire ? DS_SKIP : DS_PARAM;
              `QMWB_OP_LOCK, `QMWB_OP_UNLOCK: d.st = DS_ADDR;
              // reads handled here only in four-wire mode
              default: d.st = (is_read(sh_n[7:0]) && q.four_wire) ? DS_ADDR : DS_SKIP;
            endcase
          end
        end
        DS_ADDR: begin
          d.sh  = sh_n;
          d.cnt = cnt_n;
          if (cnt_n == abits) begin
            d.addr = i_four_byte_addr ? sh_n : {8'h00, sh_n[23:0]};
            d.cnt  = 6'd0;
            d.st   = is_read(q.opc) ? DS_DUMMY : DS_HOLD;
          end
        end
        DS_PARAM: begin
          d.sh  = sh_n;
          d.cnt = cnt_n;
          if (cnt_n == pbits) begin
            d.st = DS_SKIP;
            if (q.opc == `QMWB_OP_SET_PARAM) begin
              d.dummy_fld = sh_n[`QMWB_DUMMY_FLD_LSB +: 2];
              d.wrap_fld  = sh_n[`QMWB_WRAP_FLD_LSB +: 2];
            end else begin
              d.wrap_fld = sh_n[`QMWB_SWRAP_FLD_LSB +: 2];
            end
          end
        end
        DS_DUMMY: begin
          // dummy clocks count one per rise, whatever the lane width
          d.cnt = q.cnt + 6'd1;
          if (q.cnt + 6'd1 == {2'b00, dummy_of(q.dummy_fld)}) begin
            d.st  = DS_DATA;
            d.req = 1'b1;
          end
        end
        // extra clocks spoil a pending mode or lock command
        DS_HOLD: d.st = DS_SKIP;
        DS_DATA: d.st = DS_DATA;
        DS_SKIP: d.st = DS_SKIP;
        default: d.st = DS_SKIP;
      endcase
    end else if (sclk_fall && q.st == DS_DATA) begin
      d.io_oe_n = 1'b0;
      d.nib     = ~q.nib;
      if (!q.nib) begin
        d.io_o = q.rbyte[7:4];
      end else begin
        d.io_o = q.rbyte[3:0];
        // wrap read stays in its window
        d.addr = next_addr(q.addr, q.opc == `QMWB_OP_WRAP_READ, q.wrap_fld);
        d.req  = 1'b1;
      end
    end
    if (i_soft_reset) begin
      d.four_wire = 1'b0;
      d.dummy_fld = `QMWB_RST_DUMMY_FLD;
      d.wrap_fld  = `QMWB_RST_WRAP_FLD;
      d.locks     = '1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      q           <= '0;
      q.st        <= DS_OPC;
      q.four_wire <= 1'b0;
      // default two dummy clocks, 8-byte wrap
      q.dummy_fld <= `QMWB_RST_DUMMY_FLD;
      q.wrap_fld  <= `QMWB_RST_WRAP_FLD;
      q.locks     <= '1;
      q.io_oe_n   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // outputs
  // lock bits rule only under the individual scheme
  assign o_query_protected = i_protect_scheme_select ? q.locks[lock_idx(i_query_addr)]
                                                     : i_legacy_protected;
  assign o_read_req        = q.req;
  assign o_read_addr       = q.addr;
  assign o_four_wire_mode  = q.four_wire;
  // serial reads use the fixed count
  assign o_dummy_clocks    = q.four_wire ? dummy_of(q.dummy_fld) : `QMWB_SERIAL_DUMMY;
  assign o_wrap_bytes      = wrap_of(q.wrap_fld);
  assign o_lock_bits       = q.locks;
  assign link.d_io_o       = q.io_o;
  assign link.d_io_oe_n    = {4{q.io_oe_n}};
endmodule : qmwb_device
`default_nettype wire

//--- hdl/qmwb_host.sv
// host controller end: register port in, framed commands out on the link
`timescale 1ns/1ps
`default_nettype none
`include "qmwb_defines.svh"
module qmwb_host
  import qmwb_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // link
  qmwb_link_if.host        link
);
  localparam logic [3:0] HALF = 4'(`QMWB_SCLK_HALF_CYC - 1);

  struct packed {
    qmwb_host_state_type st;
    qmwb_phase_type      ph;
    logic                four_wire;
    logic                four_byte;
    logic                stale;
    logic [1:0]          dummy_fld;
    logic [7:0]          opc;
    logic [31:0]         addr;
    logic [7:0]          param;
    logic [2:0]          len;
    logic [5:0]          left;
    logic [31:0]         sh;
    logic [31:0]         rx;
    logic [3:0]          div;
    logic                sclk;
    logic                cs_n;
    logic [3:0]          io_oe_n;
    logic [3:0]          s1;
    logic [3:0]          s2;
    logic [31:0]         rdata;
  } q, d;

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == `QMWB_OP_FAST_READ) || (op == `QMWB_OP_QIO_READ) ||
              (op == `QMWB_OP_WRAP_READ);
  endfunction : is_read

  always_comb begin
    logic [5:0] step;
    logic       tick;
    d       = q;
    d.s1    = link.io;
    d.s2    = q.s1;
    d.rdata = 32'h0;
    step    = q.four_wire ? 6'd4 : 6'd1;
    tick    = (q.div == HALF);
    d.div   = tick ? 4'h0 : q.div + 4'h1;
    if (i_rd) begin
      case (i_addr)
        `QMWB_REG_ADDR:   d.rdata = q.addr;
        `QMWB_REG_PARAM:  d.rdata = {24'h0, q.param};
        `QMWB_REG_CFG:    d.rdata = {30'h0, q.four_byte, q.four_wire};
        `QMWB_REG_STATUS: d.rdata = {29'h0, q.stale, q.four_wire, q.st != HS_IDLE};
        `QMWB_REG_RDATA:  d.rdata = q.rx;
        default:          d.rdata = 32'h0;
      endcase
    end
    case (q.st)
      HS_IDLE: begin
        d.div = 4'h0;
        if (i_wr && i_addr == `QMWB_REG_ADDR) d.addr = i_wdata;
        if (i_wr && i_addr == `QMWB_REG_PARAM) d.param = i_wdata[7:0];
        if (i_wr && i_addr == `QMWB_REG_CFG) begin
          d.four_wire = i_wdata[0];
          d.four_byte = i_wdata[1];
        end
        if (i_wr && i_addr == `QMWB_REG_CMD) begin
          d.opc     = i_wdata[7:0];
          d.len     = i_wdata[10:8];
          d.st      = HS_CS;
          d.ph      = HP_OPC;
          d.cs_n    = 1'b0;
          d.sh      = {i_wdata[7:0], 24'h0};
          d.left    = q.four_wire ? 6'd2 : 6'd8;
          d.io_oe_n = q.four_wire ? 4'h0 : 4'hE;
        end
      end
      HS_CS: if (tick) begin
        d.st   = HS_RUN;
        d.sclk = 1'b1;
      end
      HS_RUN: if (tick) begin
        d.sclk = ~q.sclk;
        if (!q.sclk && q.ph == HP_DATA) begin
          d.rx = q.four_wire ? {q.rx[27:0], q.s2} : {q.rx[30:0], q.s2[1]};
        end
        if (q.sclk) begin
          d.sclk = 1'b0;
          d.left = q.left - 6'd1;
          d.sh   = q.four_wire ? {q.sh[27:0], 4'h0} : {q.sh[30:0], 1'b0};
          if (q.left == 6'd1) begin
            d.st = HS_END;
            case (q.ph)
              HP_OPC: if (is_read(q.opc) || q.opc == `QMWB_OP_LOCK ||
                          q.opc == `QMWB_OP_UNLOCK) begin
                d.st   = HS_RUN;
                d.ph   = HP_ADDR;
                d.sh   = q.four_byte ? q.addr : {q.addr[23:0], 8'h00};
                d.left = (q.four_byte ? 6'd32 : 6'd24) / step;
              end else if (q.opc == `QMWB_OP_SET_PARAM ||
                           q.opc == `QMWB_OP_SET_WRAP) begin
                d.st   = HS_RUN;
                d.ph   = HP_PARAM;
                d.sh   = (q.opc == `QMWB_OP_SET_PARAM) ? {q.param, 24'h0} : {24'h0, q.param};
                d.left = ((q.opc == `QMWB_OP_SET_PARAM) ? 6'd8 : 6'd32) / step;
              end
              HP_ADDR: if (is_read(q.opc)) begin
                d.st      = HS_RUN;
                d.ph      = HP_DUMMY;
                d.io_oe_n = 4'hF;
                d.left    = {1'b0, q.dummy_fld, 1'b0} + 6'd2;
              end
              HP_DUMMY: begin
                d.st   = HS_RUN;
                d.ph   = HP_DATA;
                d.left = {q.len, 3'h0} / step;
              end
              default: d.st = HS_END;
            endcase
          end
        end
      end
      HS_END: if (tick) begin
        // chip select high closes the frame
        d.st      = HS_IDLE;
        d.cs_n    = 1'b1;
        d.io_oe_n = 4'hF;
        if (q.opc == `QMWB_OP_ENTER_4W) begin
          d.four_wire = 1'b1;
          // dummy count must be programmed again
          d.stale = 1'b1;
        end
        if (q.opc == `QMWB_OP_EXIT_4W) d.four_wire = 1'b0;
        if (q.opc == `QMWB_OP_SET_PARAM && q.four_wire) begin
          d.dummy_fld = q.param[`QMWB_DUMMY_FLD_LSB +: 2];
          d.stale     = 1'b0;
        end
      end
      default: d.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      q         <= '0;
      q.st      <= HS_IDLE;
      q.cs_n    <= 1'b1;
      q.io_oe_n <= 4'hF;
      q.s1      <= 4'hF;
      q.s2      <= 4'hF;
    end else begin
      q <= d;
    end
  end

  assign o_rdata        = q.rdata;
  assign link.cs_n      = q.cs_n;
  assign link.sclk      = q.sclk;
  assign link.h_io_o    = q.four_wire ? q.sh[31:28] : {3'h0, q.sh[31]};
  assign link.h_io_oe_n = q.io_oe_n;
endmodule : qmwb_host
`default_nettype wire

//--- test/qmwb_checker.sv
// link and device-state assertions beside the joined link
`timescale 1ns/1ps
`default_nettype none
`include "qmwb_defines.svh"
module qmwb_checker (
  // clock and resets
  input wire logic                         i_clock,
  input wire logic                         i_rst,
  input wire logic                         i_soft_reset,
  // link
  input wire logic                         cs_n,
  input wire logic                         sclk,
  input wire logic [3:0]                   h_io_oe_n,
  input wire logic [3:0]                   d_io_oe_n,
  // device state
  input wire logic                         o_four_wire_mode,
  input wire logic [3:0]                   o_dummy_clocks,
  input wire logic [6:0]                   o_wrap_bytes,
  input wire logic [`QMWB_LOCK_BLOCKS-1:0] o_lock_bits
);
  // ==========================================
  // cycles since chip select went high
  logic [3:0] hi_q;
  always_ff @(posedge i_clock) begin
    if (i_rst || !cs_n) hi_q <= 4'h0;
    else if (hi_q != 4'hF) hi_q <= hi_q + 4'h1;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst || i_soft_reset);
  sequence s_frame_closed;
    cs_n && hi_q != 4'h0 && hi_q < 4'h9;
  endsequence
  // ==========================================
  // assertions
  a_reset_defaults:
  assert property ($past(i_rst) |-> !o_four_wire_mode && o_dummy_clocks == 4'h8
    && o_wrap_bytes == 7'h08 && &o_lock_bits) else $error("state wrong after reset");
  a_serial_dummy:
  assert property (!o_four_wire_mode |-> o_dummy_clocks == 4'h8) else $error("serial dummy");
  a_dummy_decode:
  assert property (o_four_wire_mode |-> o_dummy_clocks inside {4'h2, 4'h4, 4'h6, 4'h8})
    else $error("dummy count out of set");
  a_wrap_decode:
  assert property (o_wrap_bytes inside {7'h08, 7'h10, 7'h20, 7'h40}) else $error("wrap length");
  a_mode_frame_end:
  assert property ($changed(o_four_wire_mode) |-> s_frame_closed) else $error("mode moved");
  a_lock_frame_end:
  assert property ($changed(o_lock_bits) |-> s_frame_closed) else $error("lock bits moved");
  a_wrap_in_frame:
  assert property ($changed(o_wrap_bytes) |-> !cs_n) else $error("wrap moved outside a frame");
  a_dev_release:
  assert property (cs_n && hi_q > 4'h5 |-> &d_io_oe_n) else $error("device drives idle link");
  a_no_contention:
  assert property (&(h_io_oe_n | d_io_oe_n)) else $error("both ends drive a line");
  a_sclk_idle:
  assert property (cs_n && hi_q > 4'h8 |-> !sclk) else $error("link clock not idle low");
endmodule : qmwb_checker
`default_nettype wire

//--- test/qmwb_bench.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "qmwb_defines.svh"
module qmwb_bench;
  import qmwb_pkg::*;
  logic        i_clock, i_rst, i_wr, i_rd, i_soft_reset, qe, fourb, scheme, legacy, pend, prot;
  logic        four_wire;
  logic [7:0]  i_addr, b;
  logic [31:0] i_wdata, o_rdata, query, rd_addr, seed, e;
  logic [3:0]  dummy;
  logic [6:0]  wrap;
  logic [15:0] locks;
  logic [31:0] exp_q[$], msk_q[$];
  logic [7:0]  ops[3] = '{`QMWB_OP_WRAP_READ, `QMWB_OP_FAST_READ, `QMWB_OP_QIO_READ};
  int          n_errors = 0, n_compared = 0, cycles = 0;
  // ==========================================
  // ends and checker
  qmwb_link_if link ();
  qmwb_host u_qmwb_host (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(link));
  qmwb_device u_qmwb_device (.i_clock(i_clock), .i_rst(i_rst), .link(link),
    .i_soft_reset(i_soft_reset), .i_quad_enable_bit(qe), .i_four_byte_addr(fourb),
    .i_protect_scheme_select(scheme), .i_legacy_protected(legacy), .i_query_addr(query),
    .o_query_protected(prot), .o_read_req(), .o_read_addr(rd_addr),
    .i_read_data(rd_addr[7:0] ^ 8'h5A), .o_four_wire_mode(four_wire),
    .o_dummy_clocks(dummy), .o_wrap_bytes(wrap), .o_lock_bits(locks));
  qmwb_checker u_qmwb_checker (.i_clock(i_clock), .i_rst(i_rst), .i_soft_reset(i_soft_reset),
    .cs_n(link.cs_n), .sclk(link.sclk), .h_io_oe_n(link.h_io_oe_n),
    .d_io_oe_n(link.d_io_oe_n), .o_four_wire_mode(four_wire), .o_dummy_clocks(dummy),
    .o_wrap_bytes(wrap), .o_lock_bits(locks));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    n_compared++;
    if (g !== ex) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
    exp_q.push_back(ex & m);
    msk_q.push_back(m);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask : rd
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input logic [7:0] p);
    int n;
    n = 0;
    bus(1'b1, 1'b0, `QMWB_REG_ADDR, a);
    bus(1'b1, 1'b0, `QMWB_REG_PARAM, {24'h0, p});
    bus(1'b1, 1'b0, `QMWB_REG_CMD, {21'h0, 3'h4, op});
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    do begin
      rd(`QMWB_REG_STATUS, 32'h0, 32'h0);
      bus(1'b0, 1'b0, 8'h00, 32'h0);
      @(posedge i_clock);
      n++;
    end while (o_rdata[0] !== 1'b0 && n < 600);
    if (n == 600) chk("frame_busy", 32'h0, {31'h0, o_rdata[0]});
    repeat (8) @(posedge i_clock);
  endtask : frame
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // read data checked the cycle after each read strobe
  always @(posedge i_clock) begin
    if (pend) chk("rdata", exp_q.pop_front(), o_rdata & msk_q.pop_front());
    pend = i_rd;
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      end_sim();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata, pend} = {1'b1, 43'h0};
    {i_soft_reset, qe, fourb, scheme, legacy, query} = {5'h0, 32'h00500000};
    seed = 32'h7B80;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    chk("mode", 32'h0, four_wire);
    chk("wrap", 32'h8, wrap);
    chk("locks", 32'hFFFF, locks);
    rd(8'h3C, 32'h0, 32'hFFFFFFFF);
    frame(`QMWB_OP_SET_PARAM, 32'h0, 8'h33);
    chk("wrap", 32'h8, wrap);
    frame(`QMWB_OP_SET_WRAP, 32'h0, 8'h10);
    chk("wrap", 32'h10, wrap);
    frame(`QMWB_OP_ENTER_4W, 32'h0, 8'h00);
    chk("mode", 32'h0, four_wire);
    // host assumed the refused enter worked; put it back to serial
    bus(1'b1, 1'b0, `QMWB_REG_CFG, 32'h0);
    qe <= 1'b1;
    frame(`QMWB_OP_ENTER_4W, 32'h0, 8'h00);
    bus(1'b1, 1'b0, `QMWB_REG_CFG, 32'h1);
    chk("mode", 32'h1, four_wire);
    chk("wrap", 32'h10, wrap);
    chk("dummy", 32'h2, dummy);
    rd(`QMWB_REG_STATUS, 32'h4, 32'h4);
    for (int i = 0; i < 4; i++) begin
      frame(`QMWB_OP_SET_PARAM, 32'h0, {2'b00, 2'(i), 2'b00, seed[1:0]});
      chk("dummy", 32'(2 + 2 * i), dummy);
      chk("wrap", 32'h8 << seed[1:0], wrap);
      seed = xs(seed);
    end
    rd(`QMWB_REG_STATUS, 32'h0, 32'h4);
    frame(`QMWB_OP_SET_PARAM, 32'h0, 8'h11);
    foreach (ops[k]) begin
      frame(ops[k], 32'h0012340E, 8'h00);
      e = 32'h0;
      for (int i = 0; i < 4; i++) begin
        b = 8'h0E + 8'(i);
        if (ops[k] == `QMWB_OP_WRAP_READ) b = b & 8'h0F;
        e = {e[23:0], b ^ 8'h5A};
      end
      rd(`QMWB_REG_RDATA, e, 32'hFFFFFFFF);
    end
    $display("test four-wire reads done");
    frame(`QMWB_OP_EXIT_4W, 32'h0, 8'h00);
    bus(1'b1, 1'b0, `QMWB_REG_CFG, 32'h0);
    chk("mode", 32'h0, four_wire);
    chk("wrap", 32'h10, wrap);
    scheme <= 1'b1;
    frame(`QMWB_OP_UNLOCK, 32'h0050ABCD, 8'h00);
    chk("locks", 32'hFFDF, locks);
    chk("prot", 32'h0, prot);
    frame(`QMWB_OP_LOCK, 32'h0050ABCD, 8'h00);
    chk("prot", 32'h1, prot);
    fourb <= 1'b1;
    bus(1'b1, 1'b0, `QMWB_REG_CFG, 32'h2);
    frame(`QMWB_OP_UNLOCK, 32'h7F9A0000, 8'h00);
    chk("locks", 32'hFDFF, locks);
    scheme <= 1'b0;
    legacy <= seed[0];
    @(posedge i_clock);
    chk("prot", {31'h0, seed[0]}, prot);
    i_soft_reset <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_soft_reset <= 1'b0;
    @(posedge i_clock);
    chk("locks", 32'hFFFF, locks);
    chk("wrap", 32'h8, wrap);
    $display("test locks and reset done");
    repeat (4) @(posedge i_clock);
    end_sim();
  end
endmodule : qmwb_bench
`default_nettype wire
